// >>> hw/dcs_storage_access.sv
// Storage access engine with AHB-Lite register port
//
// Our own choices: register access over AHB-Lite and the address map.
`default_nettype none
// Functional notes
// - Flagged units digit means negative field
// - Flag beyond units digit marks field start
// - Flag-only digit decodes as minus zero
// - Flagged address units digit means indirect
// - Record mark ends records, invalid in arithmetic
// - Group mark recognised, flagged in status only
// - Numerical blank recognised, invalid in arithmetic
// - Field scan decrements until flagged digit
// - Units flag never ends scan; two digits
// - Record scan increments, stops at record mark
// - Card output moves exactly 80 digits
// - Input stores upward; tape end writes mark
// - Card 0-8-2 column stores record mark
// - Every access reads an even/odd pair
// - Readout cycle lasts 20 microseconds
// - Digits pass buffer halves and regenerate
// - Write half chosen by address units parity
// - Addressed digit goes to data register
// - Addresses wrap at installed top and zero
// - Alphameric zone digit at even address
// - Instruction is op, P, Q digits
// - Instructions start even; op loads together
// - Check bit added; even count flags error
// - Numeric digits valid only up to nine
module dcs_storage_access
  import dcs_pkg::*;
#(
  parameter int PAIRS = 30000
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  output logic [DIGIT_W-1:0] digit_o,
  output logic digit_valid_o,
  output logic busy_o
);
  localparam int AW = $clog2(PAIRS);
  // Top bits of the op and input-word fields
  localparam int OP_HI = 2;
  localparam int DIN_HI = 13;

  typedef struct packed {
    dcs_state_t st;
    dcs_op_t op;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] cnt;
    logic [TMR_W-1:0] tmr;
    logic [PAIR_W-1:0] pair;
    logic [DIGIT_W-1:0] mdr;
    logic [DIGIT_W-1:0] wr_digit;
    dcs_cfg_t cfg;
    dcs_stat_t stat;
    logic [7:0] iop;
    logic [19:0] ip;
    logic [19:0] iq;
    logic [13:0] din;
    logic din_v;
    logic dph_wr;
    logic [5:0] dph_a;
    logic [31:0] hrdata;
    logic [DIGIT_W-1:0] out_digit;
    logic out_valid;
  } dcs_regs_t;

  dcs_regs_t s_reg;
  dcs_regs_t s_next;
  logic [PAIR_W-1:0] rdata;
  logic mem_we;
  logic [PAIR_W-1:0] mem_wdata;
  logic [31:0] rd_val;
  logic [ADDR_W-1:0] top;
  logic [ADDR_W-1:0] inc1;
  logic [ADDR_W-1:0] inc2;
  logic [ADDR_W-1:0] dec1;
  logic [DIGIT_W-1:0] in_digit;
  logic [DIGIT_W-1:0] zone_digit;
  logic finish;
  dcs_info_t info;

  dcs_core_array #(
    .PAIRS(PAIRS),
    .AW(AW)
  ) u_array (
    .clock_i(clock_i),
    .ce_i(ce_i),
    .addr_i(s_reg.addr[AW:1]),
    .we_i(mem_we),
    .wdata_i(mem_wdata),
    .rdata_o(rdata)
  );

  dcs_digit_check u_check (
    .digit_i(s_reg.mdr),
    .info_o(info)
  );

  // Wrapping address arithmetic
  always_comb begin
    case (s_reg.cfg.size)
      2'h1: top = TOP_40K;
      2'h2: top = TOP_60K;
      default: top = TOP_20K;
    endcase
    inc1 = (s_reg.addr >= top) ? '0 : s_reg.addr + 16'h1;
    dec1 = (s_reg.addr == '0) ? top : s_reg.addr - 16'h1;
    // Plus-two step for op-code pairs and alpha characters
    if (s_reg.addr >= top - 16'h1) begin
      inc2 = s_reg.addr - (top - 16'h1);
    end else begin
      inc2 = s_reg.addr + 16'h2;
    end
  end

  // Digit to store for the pending input word
  always_comb begin
    zone_digit = dcs_add_check({1'b0, s_reg.din[DIN_ZONE_LO+:4]});
    if ((s_reg.din[DIN_EOR] && s_reg.cfg.tape) || (s_reg.cfg.card && s_reg.din[DIN_P082])) begin
      in_digit = DIG_RM;
    end else begin
      in_digit = dcs_add_check(s_reg.din[DIN_FLAG:0]);
    end
  end

  always_comb begin
    rd_val = '0;
    case (haddr_i[7:0])
      OFS_CTRL: rd_val = {28'h0, busy_o, s_reg.op};
      OFS_ADDR: rd_val = {16'h0, s_reg.start};
      OFS_CFG: rd_val = {26'h0, s_reg.cfg};
      OFS_STAT: rd_val = {22'h0, busy_o, s_reg.stat};
      OFS_CUR: rd_val = {9'h0, s_reg.cnt, s_reg.addr};
      OFS_MDR: rd_val = {26'h0, s_reg.mdr};
      OFS_IOP: rd_val = {24'h0, s_reg.iop};
      OFS_IP: rd_val = {12'h0, s_reg.ip};
      OFS_IQ: rd_val = {12'h0, s_reg.iq};
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.out_valid = 1'b0;
    mem_we = 1'b0;
    mem_wdata = s_reg.pair;
    finish = 1'b0;
    // Address phase: capture target, prepare read data for the data phase
    // Registered here for zero wait states; a read right after
    // a write to the same register therefore sees the old value
    s_next.dph_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_next.dph_wr = hwrite_i;
      s_next.dph_a = haddr_i[7:2];
      if (!hwrite_i) begin
        s_next.hrdata = rd_val;
      end
    end
    case (s_reg.st)
      ST_RD: s_next.st = ST_CAP;
      ST_CAP: begin
        // Array output is registered: valid one cycle after RD
        s_next.pair = rdata;
        s_next.mdr = s_reg.addr[0] ? rdata[DIGIT_W-1:0] : rdata[PAIR_W-1:DIGIT_W];
        s_next.tmr = '0;
        s_next.st = ST_WB;
      end
      ST_WB: begin
        if (s_reg.op == OP_WRITE || s_reg.op == OP_REC_IN) begin
          if (s_reg.op == OP_REC_IN && s_reg.cfg.alpha && !s_reg.din[DIN_EOR]) begin
            mem_wdata = {zone_digit, s_reg.wr_digit};
          end else if (s_reg.addr[0]) begin
            mem_wdata = {s_reg.pair[PAIR_W-1:DIGIT_W], s_reg.wr_digit};
          end else begin
            mem_wdata = {s_reg.wr_digit, s_reg.pair[DIGIT_W-1:0]};
          end
          s_next.mdr = s_reg.wr_digit;
        end
        mem_we = 1'b1;
        s_next.pair = mem_wdata;
        s_next.st = ST_HOLD;
      end
      ST_HOLD: begin
        // Pads the access to one full storage cycle before any new address
        s_next.tmr = s_reg.tmr + 12'h1;
        if (s_reg.tmr == HOLD_LAST) begin
          s_next.st = ST_STEP;
        end
      end
      ST_STEP: begin
        // Parity judged on the digit just read or written
        s_next.st = ST_RD;
        if (!info.parity_ok) begin
          s_next.stat.par_err = 1'b1;
        end
        if (info.group_mark) begin
          s_next.stat.gmark = 1'b1;
        end
        s_next.cnt = s_reg.cnt + 7'h1;
        case (s_reg.op)
          OP_FIELD: begin
            if (info.record_mark || info.num_blank || !info.numeric_ok) begin
              s_next.stat.arith_bad = 1'b1;
            end
            s_next.stat.mzero = info.minus_zero;
            if (s_reg.cnt == '0) begin
              s_next.stat.neg = info.flag;
            end else if (info.flag) begin
              finish = 1'b1;
            end
            s_next.addr = dec1;
          end
          OP_REC_OUT, OP_CARD_OUT: begin
            if (s_reg.op == OP_REC_OUT && info.record_mark) begin
              finish = 1'b1;
            end else begin
              s_next.out_digit = s_reg.mdr;
              s_next.out_valid = 1'b1;
              s_next.addr = inc1;
              if (s_reg.op == OP_CARD_OUT && s_next.cnt == CARD_COLS) begin
                finish = 1'b1;
              end
            end
          end
          OP_INSTR: begin
            if (s_reg.cnt == '0) begin
              s_next.iop = {s_reg.pair[PAIR_W-3:DIGIT_W], s_reg.pair[3:0]};
              s_next.cnt = OP_DIGITS;
              s_next.addr = inc2;
            end else begin
              if (s_reg.cnt <= P_UNITS) begin
                s_next.ip = {s_reg.ip[15:0], s_reg.mdr[3:0]};
              end else begin
                s_next.iq = {s_reg.iq[15:0], s_reg.mdr[3:0]};
              end
              if (s_reg.cnt == P_UNITS) begin
                s_next.stat.ind_p = s_reg.cfg.ind_en && info.flag;
              end
              if (s_reg.cnt == Q_UNITS) begin
                s_next.stat.ind_q = s_reg.cfg.ind_en && info.flag;
                finish = 1'b1;
              end
              s_next.addr = inc1;
            end
          end
          OP_REC_IN: begin
            s_next.st = ST_WAITIN;
            s_next.addr = s_reg.cfg.alpha ? inc2 : inc1;
            if (s_reg.din[DIN_EOR]) begin
              finish = 1'b1;
            end
          end
          default: finish = 1'b1;
        endcase
      end
      ST_WAITIN: begin
        if (s_reg.din_v) begin
          s_next.din_v = 1'b0;
          s_next.wr_digit = in_digit;
          if (s_reg.din[DIN_EOR] && !s_reg.cfg.tape) begin
            finish = 1'b1;
          end else begin
            s_next.st = ST_RD;
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (finish) begin
      s_next.st = ST_IDLE;
      s_next.stat.done = 1'b1;
    end
    // Data phase register writes
    if (s_reg.dph_wr) begin
      case ({s_reg.dph_a, 2'b00})
        OFS_ADDR: s_next.start = hwdata_i[ADDR_W-1:0];
        OFS_CFG: s_next.cfg = hwdata_i[$bits(dcs_cfg_t)-1:0];
        OFS_MDR: s_next.wr_digit = dcs_add_check(hwdata_i[DIN_FLAG:0]);
        OFS_DIN: begin
          // One word at a time: a second word would overwrite the
          // end-of-record bit that the running access still reads
          if (s_reg.st == ST_WAITIN && !s_reg.din_v) begin
            s_next.din = hwdata_i[DIN_HI:0];
            s_next.din_v = 1'b1;
          end
        end
        OFS_CTRL: begin
          // Start requests while busy are dropped
          if (s_reg.st == ST_IDLE && hwdata_i[CTRL_START]) begin
            s_next.op = dcs_op_t'(hwdata_i[OP_HI:0]);
            s_next.addr = s_reg.start;
            s_next.cnt = '0;
            s_next.stat = '0;
            s_next.din = '0;
            s_next.din_v = 1'b0;
            s_next.st = ST_RD;
            if (s_next.op == OP_REC_IN) begin
              s_next.st = ST_WAITIN;
            end
            if ((s_next.op == OP_INSTR && s_reg.start[0]) ||
                (s_next.op == OP_REC_IN && s_reg.cfg.alpha && !s_reg.start[0])) begin
              s_next.stat.align_err = 1'b1;
              s_next.stat.done = 1'b1;
              s_next.st = ST_IDLE;
            end
          end
        end
        default: s_next.start = s_reg.start;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    // Storage array keeps its contents: core is not reset
    if (!rst_b_i) begin
      s_reg <= '{st: ST_IDLE, op: OP_FIELD, default: '0};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_reg.hrdata;
  assign digit_o = s_reg.out_digit;
  assign digit_valid_o = s_reg.out_valid;
  assign busy_o = s_reg.st != ST_IDLE;
endmodule // dcs_storage_access
`default_nettype wire

// >>> pkg/dcs_pkg.sv
// Shared constants, types and helpers for the decimal storage access block
`default_nettype none
package dcs_pkg;
  localparam int ADDR_W = 16;
  localparam int DIGIT_W = 6;
  localparam int PAIR_W = 12;
  localparam int CNT_W = 7;
  localparam int TMR_W = 12;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CUR = 8'h10;
  localparam logic [7:0] OFS_MDR = 8'h14;
  localparam logic [7:0] OFS_DIN = 8'h18;
  localparam logic [7:0] OFS_IOP = 8'h1c;
  localparam logic [7:0] OFS_IP = 8'h20;
  localparam logic [7:0] OFS_IQ = 8'h24;
  // Field positions
  localparam int CTRL_START = 3;
  localparam int DIN_FLAG = 4;
  localparam int DIN_EOR = 8;
  localparam int DIN_P082 = 9;
  localparam int DIN_ZONE_LO = 10;
  localparam int CUR_CNT_LO = 16;
  // Digit layout {C,F,8,4,2,1}
  localparam int BIT_C = 5;
  localparam int BIT_F = 4;
  localparam logic [3:0] NUM_MAX = 4'h9;
  localparam logic [3:0] NUM_RM = 4'ha;
  localparam logic [3:0] NUM_NB = 4'hc;
  localparam logic [3:0] NUM_GM = 4'hf;
  localparam logic [5:0] DIG_RM = 6'h2a;
  localparam logic [5:0] DIG_MZ = 6'h10;
  // Installed top addresses
  localparam logic [ADDR_W-1:0] TOP_20K = 16'h4e1f;
  localparam logic [ADDR_W-1:0] TOP_40K = 16'h9c3f;
  localparam logic [ADDR_W-1:0] TOP_60K = 16'hea5f;
  localparam logic [CNT_W-1:0] CARD_COLS = 7'h50;
  localparam logic [CNT_W-1:0] OP_DIGITS = 7'h02;
  localparam logic [CNT_W-1:0] P_UNITS = 7'h06;
  localparam logic [CNT_W-1:0] Q_UNITS = 7'h0b;
  // Storage cycle timing
  localparam int ACCESS_TIME_NS = 20000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ACCESS_CYC = ACCESS_TIME_NS / CLK_PERIOD_NS;
  localparam int FIXED_STATES = 4;
  localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(ACCESS_CYC - FIXED_STATES - 1);

  typedef enum logic [2:0] {
    OP_FIELD = 3'h0, OP_REC_OUT = 3'h1, OP_CARD_OUT = 3'h2, OP_REC_IN = 3'h3,
    OP_INSTR = 3'h4, OP_READ = 3'h5, OP_WRITE = 3'h6
  } dcs_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_RD = 7'h02, ST_CAP = 7'h04, ST_WB = 7'h08,
    ST_HOLD = 7'h10, ST_STEP = 7'h20, ST_WAITIN = 7'h40
  } dcs_state_t;

  typedef struct packed {
    logic alpha;
    logic card;
    logic tape;
    logic ind_en;
    logic [1:0] size;
  } dcs_cfg_t;

  typedef struct packed {
    logic ind_q;
    logic ind_p;
    logic align_err;
    logic gmark;
    logic mzero;
    logic neg;
    logic arith_bad;
    logic par_err;
    logic done;
  } dcs_stat_t;

  typedef struct packed {
    logic parity_ok;
    logic flag;
    logic numeric_ok;
    logic record_mark;
    logic group_mark;
    logic num_blank;
    logic minus_zero;
  } dcs_info_t;

  // Check bit makes the total bit count odd
  function automatic logic [DIGIT_W-1:0] dcs_add_check(input logic [4:0] fv);
    dcs_add_check = {~(^fv), fv};
  endfunction
endpackage : dcs_pkg
`default_nettype wire

// >>> hw/dcs_core_array.sv
// Paired-digit storage array with registered read data
`default_nettype none
module dcs_core_array
  import dcs_pkg::*;
#(
  parameter int PAIRS = 30000,
  parameter int AW = 15
) (
  input wire logic clock_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic we_i,
  input wire logic [PAIR_W-1:0] wdata_i,
  output logic [PAIR_W-1:0] rdata_o
);
  // Both planes of a pair share one word, so every access touches both digits
  logic [PAIR_W-1:0] mem [PAIRS];

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule // dcs_core_array
`default_nettype wire

// >>> hw/dcs_digit_check.sv
// Digit classifier: parity, flag, special codes
`default_nettype none
module dcs_digit_check
  import dcs_pkg::*;
(
  input wire logic [DIGIT_W-1:0] digit_i,
  output dcs_info_t info_o
);
  always_comb begin
    info_o.parity_ok = ^digit_i;
    info_o.flag = digit_i[BIT_F];
    info_o.numeric_ok = digit_i[3:0] <= NUM_MAX;
    info_o.record_mark = digit_i[3:0] == NUM_RM;
    info_o.group_mark = digit_i[3:0] == NUM_GM;
    info_o.num_blank = digit_i[3:0] == NUM_NB;
    info_o.minus_zero = digit_i == DIG_MZ;
  end
endmodule // dcs_digit_check
`default_nettype wire

// >>> test/dcs_digit_sink.sv
// Output-side model: collects digits emitted by record transfers
`default_nettype none
module dcs_digit_sink
  import dcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic clear_i,
  input wire logic [DIGIT_W-1:0] digit_i,
  input wire logic valid_i,
  output logic [7:0] count_o,
  output logic [17:0] last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Newest digit enters at the low end
  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      count_o <= 8'h00;
      last_o <= 18'h00000;
    end else if (valid_i) begin
      count_o <= count_o + 8'h01;
      last_o <= {last_o[11:0], digit_i};
    end
  end
endmodule // dcs_digit_sink
`default_nettype wire

// >>> test/dcs_storage_access_props.sv
// Port-level assertions for the storage access block
`default_nettype none
module dcs_storage_access_props
  import dcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic [31:0] hrdata_o,
  input wire logic hresp_o,
  input wire logic [DIGIT_W-1:0] digit_o,
  input wire logic digit_valid_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP_MIN = ACCESS_CYC - 1;
  logic [TMR_W-1:0] gap_reg;
  logic seen_reg;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Cycles since the last digit pulse, saturating
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || digit_valid_o) begin
      gap_reg <= '0;
    end else if (gap_reg != '1) begin
      gap_reg <= gap_reg + 1'b1;
    end
    seen_reg <= rst_b_i && (seen_reg || digit_valid_o);
  end
  sequence ctrl_wr_s;
    (hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == OFS_CTRL && !busy_o)
    ##1 (hwdata_i[CTRL_START] && hwdata_i[2:0] != 3'h4);
  endsequence
  pulse_one_a: assert property (digit_valid_o |=> !digit_valid_o)
    else $error("digit pulse longer than one cycle");
  pulse_gap_a: assert property (digit_valid_o && seen_reg |-> gap_reg >= GAP_MIN)
    else $error("digit accesses closer than one storage cycle");
  pulse_busy_a: assert property ($rose(digit_valid_o) |-> $past(busy_o))
    else $error("digit pulse outside an operation");
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_b_i |=> !busy_o && !digit_valid_o && hrdata_o == 32'h0)
    else $error("outputs not idle after reset");
  digit_parity_a: assert property (digit_valid_o |-> ^digit_o)
    else $error("emitted digit has even bit count");
  digit_hold_a: assert property (!digit_valid_o |-> $stable(digit_o))
    else $error("digit output changed without pulse");
  start_busy_a: assert property (ctrl_wr_s |-> ##[1:2] busy_o)
    else $error("start did not begin an operation");
endmodule // dcs_storage_access_props
`default_nettype wire

// >>> test/test_decimal_core_storage_access.sv
// Register-level testbench for the storage access block
`default_nettype none
module test_decimal_core_storage_access
  import dcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [DIGIT_W-1:0] digit;
  logic digit_valid;
  logic busy;
  logic sink_clr = 1'b1;
  logic [7:0] sink_cnt;
  logic [17:0] sink_last;
  logic [31:0] v;
  int fails = 0;
  int cmp_count = 0;

  dcs_storage_access DUT (.clock_i(clock_i), .rst_b_i(rst_b), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(),
    .digit_o(digit), .digit_valid_o(digit_valid), .busy_o(busy));
  dcs_digit_sink u_sink (.clock_i(clock_i), .clear_i(sink_clr), .digit_i(digit),
    .valid_i(digit_valid), .count_o(sink_cnt), .last_o(sink_last));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic results();
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // Waits on a level with a bound; running out ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        results();
      end
      @(posedge clock_i);
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0, q);
  endtask

  // Start an operation and wait for it to finish
  task automatic run(input logic [2:0] op, input logic [15:0] a);
    int n;
    bus_wr(OFS_ADDR, {16'h0, a});
    bus_wr(OFS_CTRL, {28'h0, 1'b1, op});
    repeat (2) @(posedge clock_i);
    n = 0;
    while (busy !== 1'b0) begin
      n++;
      if (n > 40000) begin
        fails++;
        results();
      end
      @(posedge clock_i);
    end
  endtask

  // Polls the digit count until it reaches k; a long wait ends the run
  task automatic wait_cur(input logic [6:0] k);
    int n;
    logic [31:0] q;
    n = 0;
    bus_rd(OFS_CUR, q);
    while (q[22:16] !== k) begin
      n++;
      if (n > 3000) begin
        fails++;
        results();
      end
      bus_rd(OFS_CUR, q);
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [4:0] fv);
    bus_wr(OFS_MDR, {27'h0, fv});
    run(3'h6, a);
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    rst_b <= 1'b1;
    sink_clr <= 1'b0;
    bus_rd(OFS_STAT, v); chk("stat reset", 32'h0, v);
    bus_rd(OFS_MDR, v); chk("mdr reset", 32'h0, v);
    bus_wr(8'h40, 32'h5a);
    bus_rd(8'h40, v); chk("unmapped", 32'h0, v);
    bus_wr(OFS_CFG, 32'h3e);
    bus_rd(OFS_CFG, v); chk("cfg", 32'h3e, v);
    bus_wr(OFS_CFG, 32'h0);
    // Field 19999..1 wraps across zero; digit 2 holds a record mark
    put(TOP_20K, 5'h13);
    put(16'h0000, 5'h05);
    put(16'h0001, 5'h11);
    put(16'h0002, 5'h0a);
    run(3'h5, 16'h0000);
    bus_rd(OFS_MDR, v); chk("mdr even", 32'h25, v);
    run(3'h5, 16'h0001);
    bus_rd(OFS_MDR, v); chk("mdr odd", 32'h31, v);
    run(3'h5, 16'h0002);
    bus_rd(OFS_MDR, v); chk("mdr mark", {26'h0, DIG_RM}, v);
    run(3'h0, 16'h0001);
    bus_rd(OFS_STAT, v); chk("field stat", 32'h9, v);
    run(3'h1, TOP_20K);
    chk("record count", 32'h3, {24'h0, sink_cnt});
    chk("record digits", 32'h13, {26'h0, sink_last[17:12]});
    chk("record tail", {20'h0, 6'h25, 6'h31}, {20'h0, sink_last[11:0]});
    run(3'h4, 16'h0001);
    bus_rd(OFS_STAT, v); chk("odd instr", 32'h41, v);
    // Tape record in: one digit, then end of record writes a mark
    bus_wr(OFS_CFG, 32'h8);
    bus_wr(OFS_ADDR, 32'h100);
    bus_wr(OFS_CTRL, {28'h0, 1'b1, 3'h3});
    bus_wr(OFS_DIN, 32'h7);
    wait_cur(7'h1);
    bus_wr(OFS_DIN, 32'h100);
    wait_cur(7'h2);
    bus_rd(OFS_CUR, v); chk("record in end", 32'h00020102, v);
    bus_rd(OFS_STAT, v); chk("record in stat", 32'h1, v);
    run(3'h5, 16'h0101);
    bus_rd(OFS_MDR, v); chk("tape mark", {26'h0, DIG_RM}, v);
    results();
  end
endmodule // test_decimal_core_storage_access

bind dcs_storage_access dcs_storage_access_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o),
  .hresp_o(hresp_o), .digit_o(digit_o), .digit_valid_o(digit_valid_o), .busy_o(busy_o));
`default_nettype wire
